//--- bench/rmhi_host_model.sv
`timescale 1ns/1ns
module rmhi_host_model
  import rmhi_pkg::*;
#(
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic clk,
  input  wire logic host_txd,
  output logic      host_rxd
);
  // Line idles high between frames, as a real host's transmitter does
  initial host_rxd = 1'b1;

  // ==========================================================
  // Transmit one frame: start, eight bits LSB first, stop
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] frame;
    frame = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      host_rxd <= frame[i];
      repeat (BIT_CYC - 1) @(posedge clk);
    end
  endtask

  // ==========================================================
  // Receive one frame; got stays low if no start bit in time
  // Sampling at mid-bit keeps us clear of edge skew
  task automatic recv_byte(output logic [7:0] b, output logic got,
                           input int limit);
    int n;
    b = 8'h00;
    got = 1'b0;
    n = 0;
    while (host_txd === 1'b1 && n < limit) begin
      @(posedge clk);
      n++;
    end
    if (host_txd === 1'b0) begin
      repeat (BIT_CYC / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CYC) @(posedge clk);
        b[i] = host_txd;
      end
      repeat (BIT_CYC) @(posedge clk);
      got = (host_txd === 1'b1);
    end
  endtask
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ns
module testbench
  import rmhi_pkg::*;
;
  logic       clk;
  logic       rst;
  logic       host_reset_n;
  logic       mode_select_pin;
  logic       host_rxd;
  logic       host_txd;
  logic       tx_in_progress;
  logic       reset_occurred_flag;
  logic       radio_tx_en;
  logic       ant_tx_path;
  logic       radio_rx_en;
  logic       low_power;
  logic [7:0] hop_channel;
  logic [7:0] radio_tx_data;
  logic       radio_tx_valid;
  logic [7:0] radio_rx_data;
  logic       radio_rx_valid;
  logic       radio_rx_last;
  logic       radio_rx_crc_ok;
  int         miscompares;
  int         tests_run;
  int         cycles;
  int         n;
  logic [7:0] txq[$];
  logic [7:0] pl[$];
  logic [7:0] own_addr;
  logic [7:0] pay;
  logic [7:0] rxpay;
  logic [7:0] got_b;
  logic [7:0] hop0;
  logic       got;
  // Short bit time keeps the run small; the design default is 9600 baud
  localparam int TB_BIT = 64;

  // Short ack wait and bit time keep the run inside the cycle budget
  rmhi_core #(.ACK_CYC(50), .BIT_CYC(TB_BIT)) i_dut (
    .clk                 (clk),
    .rst                 (rst),
    .host_reset_n        (host_reset_n),
    .mode_select_pin     (mode_select_pin),
    .host_rxd            (host_rxd),
    .host_txd            (host_txd),
    .tx_in_progress      (tx_in_progress),
    .reset_occurred_flag (reset_occurred_flag),
    .radio_tx_en         (radio_tx_en),
    .ant_tx_path         (ant_tx_path),
    .radio_rx_en         (radio_rx_en),
    .low_power           (low_power),
    .hop_channel         (hop_channel),
    .radio_tx_data       (radio_tx_data),
    .radio_tx_valid      (radio_tx_valid),
    .radio_rx_data       (radio_rx_data),
    .radio_rx_valid      (radio_rx_valid),
    .radio_rx_last       (radio_rx_last),
    .radio_rx_crc_ok     (radio_rx_crc_ok)
  );

  rmhi_host_model #(.BIT_CYC(TB_BIT)) i_host (
    .clk      (clk),
    .host_txd (host_txd),
    .host_rxd (host_rxd)
  );

  // ==========================================================
  // Clock, byte capture toward the radio, hang guard
  initial clk = 1'b0;
  always #50 clk = ~clk;

  always @(posedge clk) begin
    if (radio_tx_valid === 1'b1) begin
      txq.push_back(radio_tx_data);
    end
  end

  initial cycles = 0;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 40000) begin
      miscompares++;
      stop_test();
    end
  end

  // ==========================================================
  // Checking helpers
  function automatic logic [7:0] exp_crc(input logic [7:0] q[$]);
    logic [7:0] c;
    c = 8'h00;
    foreach (q[i]) c = c ^ q[i];
    return c;
  endfunction

  task automatic check(input string what, input logic [7:0] seen,
                       input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Two-byte radio packet: address then one payload byte
  task automatic radio_pkt(input logic [7:0] a, input logic [7:0] d,
                           input logic ok);
    for (int i = 0; i < 2; i++) begin
      @(posedge clk);
      radio_rx_valid  <= 1'b1;
      radio_rx_data   <= (i == 0) ? a : d;
      radio_rx_last   <= (i == 1);
      radio_rx_crc_ok <= ok;
    end
    @(posedge clk);
    radio_rx_valid <= 1'b0;
    radio_rx_last  <= 1'b0;
    radio_rx_data  <= ~d;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    rst = 1'b1;
    host_reset_n = 1'b1;
    mode_select_pin = 1'b1;
    radio_rx_data = 8'h00;
    radio_rx_valid = 1'b0;
    radio_rx_last = 1'b0;
    radio_rx_crc_ok = 1'b0;
    miscompares = 0;
    tests_run = 0;
    void'($urandom(32'h6A90066F));
    own_addr = 8'($urandom);
    pay = 8'($urandom);
    rxpay = 8'($urandom);
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (30) @(posedge clk);
    check("flag after reset", 8'(reset_occurred_flag), 8'h01);
    check("txd idle", 8'(host_txd), 8'h01);
    check("tx idle", 8'(tx_in_progress), 8'h00);
    $display("test reset done");

    i_host.send_byte({OPC_CLR_FLAG, 4'h0});
    repeat (20) @(posedge clk);
    check("flag cleared", 8'(reset_occurred_flag), 8'h00);
    $display("test clear done");

    // Host configures in command mode before going to data mode
    i_host.send_byte({OPC_WRITE, 4'h1});
    i_host.send_byte(8'h00);
    i_host.send_byte(own_addr);
    i_host.send_byte({OPC_READ, 4'h1});
    i_host.send_byte(8'h00);
    i_host.recv_byte(got_b, got, 4 * TB_BIT);
    check("read reply", 8'(got), 8'h01);
    check("read value", got_b, own_addr);
    $display("test registers done");

    @(posedge clk);
    mode_select_pin <= 1'b0;
    n = 0;
    while (radio_rx_en !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    check("rx in data mode", 8'(radio_rx_en), 8'h01);
    hop0 = hop_channel;
    txq.delete();
    pl = {pay};
    // The packet leaves in the middle of the stop bit, so the outputs
    // are watched while the host is still sending
    fork
      i_host.send_byte(pay);
      begin
        n = 0;
        while (tx_in_progress !== 1'b1 && n < 12 * TB_BIT) begin
          @(posedge clk);
          n++;
        end
        check("tx active", 8'(tx_in_progress), 8'h01);
        check("radio tx mode", 8'(radio_tx_en), 8'h01);
        check("antenna tx", 8'(ant_tx_path), 8'h01);
        check("hop moved", 8'(hop_channel != hop0), 8'h01);
        n = 0;
        while (tx_in_progress !== 1'b0 && n < 50) begin
          @(posedge clk);
          n++;
        end
        check("back to rx", 8'(radio_rx_en), 8'h01);
      end
    join
    check("packet length", 8'(txq.size()), 8'h03);
    check("header byte", txq[0], REG_RESET_VAL);
    check("payload byte", txq[1], pay);
    check("crc byte", txq[2], exp_crc(pl));
    $display("test transmit done");

    // Let the ack wait expire before offering receive traffic
    repeat (70) @(posedge clk);
    radio_pkt(own_addr, 8'h5A, 1'b0);
    i_host.recv_byte(got_b, got, 4 * TB_BIT);
    check("bad crc dropped", 8'(got), 8'h00);
    radio_pkt(~own_addr, 8'hA5, 1'b1);
    i_host.recv_byte(got_b, got, 4 * TB_BIT);
    check("wrong addr dropped", 8'(got), 8'h00);
    radio_pkt(own_addr, rxpay, 1'b1);
    i_host.recv_byte(got_b, got, 4 * TB_BIT);
    check("good forwarded", 8'(got), 8'h01);
    check("forwarded byte", got_b, rxpay);
    $display("test receive done");

    @(posedge clk);
    host_reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    host_reset_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("flag after host reset", 8'(reset_occurred_flag), 8'h01);
    check("tx idle after reset", 8'(tx_in_progress), 8'h00);
    $display("test host reset done");

    // Command set after the host reset; the pin is still low here
    repeat (30) @(posedge clk);
    check("data mode after init", 8'(radio_rx_en), 8'h01);
    mode_select_pin <= 1'b1;
    repeat (5) @(posedge clk);
    check("rx off in cmd mode", 8'(radio_rx_en), 8'h00);
    i_host.send_byte({OPC_SLEEP, 4'h0});
    check("sleep entered", 8'(low_power), 8'h01);
    i_host.send_byte({OPC_WAKE, 4'h0});
    check("sleep left", 8'(low_power), 8'h00);
    i_host.send_byte({OPC_CLR_FLAG, 4'h0});
    check("flag cleared again", 8'(reset_occurred_flag), 8'h00);
    // A zero count write must not swallow the bytes that follow it
    i_host.send_byte({OPC_WRITE, 4'h0});
    i_host.send_byte(START_OF_MSG);
    i_host.send_byte(8'h5A);
    check("flag kept", 8'(reset_occurred_flag), 8'h00);
    i_host.send_byte({OPC_READ, 4'h1});
    i_host.send_byte(8'h01);
    i_host.recv_byte(got_b, got, 4 * TB_BIT);
    check("zero count reply", 8'(got), 8'h01);
    check("zero count ignored", got_b, REG_RESET_VAL);
    i_host.send_byte({OPC_RESET, 4'h0});
    check("flag after reset cmd", 8'(reset_occurred_flag), 8'h01);
    check("txd after reset cmd", 8'(host_txd), 8'h01);
    $display("test commands done");
    stop_test();
  end
endmodule

//--- core/rmhi_core.sv
`timescale 1ns/1ns
module rmhi_core
  import rmhi_pkg::*;
#(
  parameter int ACK_CYC = ACK_WAIT,
  parameter int BIT_CYC = BIT_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       host_reset_n,
  input  wire logic       mode_select_pin,
  input  wire logic       host_rxd,
  output logic            host_txd,
  output logic            tx_in_progress,
  output logic            reset_occurred_flag,
  output logic            radio_tx_en,
  output logic            ant_tx_path,
  output logic            radio_rx_en,
  output logic            low_power,
  output logic [7:0]      hop_channel,
  output logic [7:0]      radio_tx_data,
  output logic            radio_tx_valid,
  input  wire logic [7:0] radio_rx_data,
  input  wire logic       radio_rx_valid,
  input  wire logic       radio_rx_last,
  input  wire logic       radio_rx_crc_ok
);
  // ==========================================================
  // Reset and input synchronisers
  logic [1:0] rs_q, ms_q, rx_q;
  logic       arst;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rs_q <= 2'h0;
      ms_q <= 2'h3;
      rx_q <= 2'h3;
    end else begin
      rs_q <= {rs_q[0], host_reset_n};
      ms_q <= {ms_q[0], mode_select_pin};
      rx_q <= {rx_q[0], host_rxd};
    end
  end
  // Only rst resets the FIFO; host reset acts on the synchronised level in the state register only
  assign arst = rst;

  // Hopping table kept as a constant, like program memory
  localparam logic [7:0] HOP_TBL [HOP_COUNT] = '{8'h03, 8'h1B, 8'h0A,
    8'h2C, 8'h11, 8'h25, 8'h06, 8'h30};

  // ==========================================================
  // State record
  typedef struct packed {
    rmhi_state_t st;
    logic [15:0] icnt;
    logic        rbusy;
    logic [15:0] rcnt;
    logic [3:0]  rbit;
    logic [7:0]  rsh;
    logic        tbusy;
    logic [15:0] tcnt;
    logic [3:0]  tbit;
    logic [9:0]  tsh;
    logic [3:0]  opc;
    logic [3:0]  cnt;
    logic [7:0]  ridx;
    logic [7:0]  pcnt;
    logic [7:0]  crc;
    logic [15:0] wait_c;
    logic [2:0]  hop;
    logic [7:0]  chan;
    logic        rflag;
    logic        rx_ok;
    logic [1:0]  rx_pos;
    logic        txd;
    rmhi_radio_t rad;
    logic [7:0]  rtxd;
    logic        rtxv;
  } rmhi_core_t;

  rmhi_core_t s_q, s_d;
  logic [7:0] regs_q [REG_COUNT];
  logic       reg_we;
  logic [7:0] reg_wa, reg_wd;
  logic       f_in_v, f_in_r, f_out_v, f_out_r;
  logic [7:0] f_in_d, f_out_d;
  logic       up_v;
  logic [7:0] up_d;
  logic       cmd_mode, rx_s, got;
  logic [7:0] gbyte;

  assign cmd_mode = ms_q[1];
  assign rx_s     = rx_q[1];

  rmhi_fifo #(.W(8), .D(4)) u_fifo (
    .clk      (clk),
    .rst      (arst),
    .in_valid (f_in_v),
    .in_ready (f_in_r),
    .in_data  (f_in_d),
    .out_valid(f_out_v),
    .out_ready(f_out_r),
    .out_data (f_out_d)
  );

  always_comb begin
    s_d     = s_q;
    reg_we  = 1'b0;
    reg_wa  = s_q.ridx;
    reg_wd  = 8'h00;
    f_in_v  = 1'b0;
    f_in_d  = 8'h00;
    f_out_r = 1'b0;
    up_v    = 1'b0;
    up_d    = 8'h00;
    got     = 1'b0;
    gbyte   = s_q.rsh;
    s_d.rtxv = 1'b0;
    // UART receiver, 8N1 at 9600 baud, sampled mid-bit
    if (!s_q.rbusy) begin
      if (!rx_s) begin
        s_d.rbusy = 1'b1;
        s_d.rcnt  = 16'(BIT_CYC / 2);
        s_d.rbit  = 4'h0;
      end
    end else if (s_q.rcnt != 16'h0) begin
      s_d.rcnt = s_q.rcnt - 16'h1;
    end else begin
      s_d.rcnt = 16'(BIT_CYC - 1);
      s_d.rbit = s_q.rbit + 4'h1;
      if (s_q.rbit == 4'h9) begin
        s_d.rbusy = 1'b0;
        got = rx_s;
      end else if (s_q.rbit != 4'h0) begin
        s_d.rsh = {rx_s, s_q.rsh[7:1]};
      end
    end
    // UART transmitter
    if (s_q.tbusy) begin
      if (s_q.tcnt != 16'h0) begin
        s_d.tcnt = s_q.tcnt - 16'h1;
      end else begin
        s_d.tcnt = 16'(BIT_CYC - 1);
        s_d.txd  = s_q.tsh[0];
        s_d.tsh  = {1'b1, s_q.tsh[9:1]};
        s_d.tbit = s_q.tbit + 4'h1;
        if (s_q.tbit == 4'h9) s_d.tbusy = 1'b0;
      end
    end
    // Radio receive filter: first byte is destination address
    if (radio_rx_valid && s_q.rad.rx_enable) begin
      s_d.rx_pos = (s_q.rx_pos == 2'h0) ? 2'h1 : 2'h2;
      if (s_q.rx_pos == 2'h0) begin
        s_d.rx_ok = (radio_rx_data == regs_q[REG_ADDR_IDX]);
      end else if (s_q.rx_ok && radio_rx_crc_ok && radio_rx_last
                   && s_q.st == RMHI_ACKW) begin
        if (radio_rx_data == ACK_CODE) begin
          s_d.st = RMHI_IDLE;
          s_d.rad.rx_enable = 1'b1;
        end
      end else if (s_q.rx_ok && radio_rx_crc_ok) begin
        up_v = 1'b1;
        up_d = radio_rx_data;
      end
      if (radio_rx_last) s_d.rx_pos = 2'h0;
    end
    if (up_v && !s_q.tbusy) begin
      s_d.tbusy = 1'b1;
      s_d.tcnt  = 16'(BIT_CYC - 1);
      s_d.tbit  = 4'h0;
      s_d.tsh   = {1'b1, up_d, 1'b0};
    end
    // Main sequencer
    case (s_q.st)
      RMHI_INIT: begin
        s_d.icnt = s_q.icnt + 16'h1;
        if (s_q.icnt == 16'(INIT_CYCLES)) begin
          s_d.st = RMHI_IDLE;
          s_d.rad.rx_enable = !cmd_mode;
        end
      end
      RMHI_IDLE: begin
        s_d.rad.rx_enable = !cmd_mode;
        if (got && cmd_mode) begin
          s_d.opc = gbyte[OPC_MSB:OPC_LSB];
          s_d.cnt = gbyte[CNT_MSB:CNT_LSB];
          if (gbyte == START_OF_MSG) begin
            s_d.st = RMHI_IDLE;
          end else if (gbyte[OPC_MSB:OPC_LSB] == OPC_RESET) begin
            s_d = '0;
            s_d.rflag = 1'b1;
            s_d.txd = 1'b1;
            s_d.st = RMHI_INIT;
          end else if (gbyte[OPC_MSB:OPC_LSB] == OPC_CLR_FLAG) begin
            s_d.rflag = 1'b0;
          end else if (gbyte[OPC_MSB:OPC_LSB] == OPC_SLEEP) begin
            s_d.st = RMHI_SLEEP;
            s_d.rad.low_power = 1'b1;
            s_d.rad.rx_enable = 1'b0;
          end else if ((gbyte[OPC_MSB:OPC_LSB] == OPC_READ
                     || gbyte[OPC_MSB:OPC_LSB] == OPC_WRITE)
                     && gbyte[CNT_MSB:CNT_LSB] != 4'h0) begin
            s_d.st = RMHI_CNUM;
          end
        end else if (got && f_in_r) begin
          f_in_v = 1'b1;
          f_in_d = gbyte;
        end
        if (!cmd_mode && f_out_v) begin
          s_d.st = RMHI_TXHDR;
          s_d.rad.tx_active = 1'b1;
          s_d.rad.tx_path   = 1'b1;
          s_d.rad.rx_enable = 1'b0;
          s_d.hop  = s_q.hop + 3'h1;
          s_d.pcnt = 8'h0;
          s_d.crc  = 8'h0;
        end
      end
      RMHI_CNUM: if (got) begin
        s_d.ridx = gbyte;
        s_d.st = (s_q.opc == OPC_WRITE) ? RMHI_CWDAT : RMHI_CRDAT;
      end
      RMHI_CWDAT: if (got) begin
        reg_we = 1'b1;
        reg_wd = gbyte;
        s_d.ridx = s_q.ridx + 8'h1;
        s_d.cnt  = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) s_d.st = RMHI_IDLE;
      end
      RMHI_CRDAT: if (!s_q.tbusy && !up_v) begin
        s_d.tbusy = 1'b1;
        s_d.tcnt  = 16'(BIT_CYC - 1);
        s_d.tbit  = 4'h0;
        s_d.tsh   = {1'b1, regs_q[s_q.ridx[3:0]], 1'b0};
        s_d.ridx  = s_q.ridx + 8'h1;
        s_d.cnt   = s_q.cnt - 4'h1;
        if (s_q.cnt == 4'h1) s_d.st = RMHI_IDLE;
      end
      RMHI_TXHDR: begin
        s_d.rtxv = 1'b1;
        s_d.rtxd = regs_q[REG_DEST_IDX];
        s_d.st   = RMHI_TXPAY;
      end
      RMHI_TXPAY: begin
        if (f_out_v && s_q.pcnt != 8'(MAX_PAYLOAD)) begin
          f_out_r  = 1'b1;
          s_d.rtxv = 1'b1;
          s_d.rtxd = f_out_d;
          s_d.crc  = s_q.crc ^ f_out_d;
          s_d.pcnt = s_q.pcnt + 8'h1;
        end else begin
          s_d.st = RMHI_TXCRC;
        end
      end
      RMHI_TXCRC: begin
        s_d.rtxv = 1'b1;
        s_d.rtxd = s_q.crc;
        s_d.st   = RMHI_ACKW;
        s_d.rad.tx_active = 1'b0;
        s_d.rad.tx_path   = 1'b0;
        s_d.rad.rx_enable = 1'b1;
        s_d.wait_c = 16'(ACK_CYC);
      end
      RMHI_ACKW: begin
        s_d.wait_c = s_q.wait_c - 16'h1;
        if (s_q.wait_c == 16'h0) s_d.st = RMHI_IDLE;
      end
      RMHI_SLEEP: if (got && cmd_mode
                      && gbyte[OPC_MSB:OPC_LSB] == OPC_WAKE) begin
        s_d.st = RMHI_IDLE;
        s_d.rad.low_power = 1'b0;
      end
      default: s_d.st = RMHI_INIT;
    endcase
    // Abort wins over any transmit stage
    if (got && cmd_mode && gbyte[OPC_MSB:OPC_LSB] == OPC_ABORT
        && s_q.rad.tx_active) begin
      s_d.st = RMHI_IDLE;
      s_d.rad.tx_active = 1'b0;
      s_d.rad.tx_path   = 1'b0;
      s_d.rtxv = 1'b0;
    end
    // Channel is registered so the output comes from a flop
    s_d.chan = HOP_TBL[s_d.hop];
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q       <= '0;
      s_q.rflag <= 1'b1;
      s_q.txd   <= 1'b1;
      s_q.chan  <= HOP_TBL[0];
    end else if (!rs_q[1]) begin
      s_q       <= '0;
      s_q.rflag <= 1'b1;
      s_q.txd   <= 1'b1;
      s_q.chan  <= HOP_TBL[0];
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < REG_COUNT; i++) regs_q[i] <= REG_RESET_VAL;
    end else if (reg_we) begin
      regs_q[reg_wa[3:0]] <= reg_wd;
    end
  end

  assign host_txd            = s_q.txd;
  assign tx_in_progress      = s_q.rad.tx_active;
  assign reset_occurred_flag = s_q.rflag;
  assign radio_tx_en         = s_q.rad.tx_active;
  assign ant_tx_path         = s_q.rad.tx_path;
  assign radio_rx_en         = s_q.rad.rx_enable;
  assign low_power           = s_q.rad.low_power;
  assign hop_channel         = s_q.chan;
  assign radio_tx_data       = s_q.rtxd;
  assign radio_tx_valid      = s_q.rtxv;

  // ==========================================================
  // Checks
  chk_flag_clear: assert property (@(posedge clk) disable iff (rst)
    (rs_q[1] && s_q.st == RMHI_IDLE && got && cmd_mode
     && gbyte[OPC_MSB:OPC_LSB] == OPC_CLR_FLAG) |=> !reset_occurred_flag)
    else $error("reset flag not cleared");
  chk_hreset_flag: assert property (@(posedge clk) disable iff (rst)
    !rs_q[1] |=> reset_occurred_flag && !tx_in_progress)
    else $error("host reset did not set flag");
  chk_tx_path: assert property (@(posedge clk) disable iff (rst)
    radio_tx_valid && s_q.st == RMHI_TXPAY |-> ant_tx_path)
    else $error("streaming without transmit path");
  chk_tx_flag: assert property (@(posedge clk) disable iff (rst)
    tx_in_progress == (s_q.st inside {RMHI_TXHDR, RMHI_TXPAY, RMHI_TXCRC}))
    else $error("activity output mismatch");
  chk_ack_wait: assert property (@(posedge clk) disable iff (rst)
    s_q.st == RMHI_TXCRC && rs_q[1] && !$past(got) |=> radio_rx_en)
    else $error("receive not enabled after send");
  chk_sleep_in: assert property (@(posedge clk) disable iff (rst)
    s_q.st == RMHI_SLEEP |-> low_power)
    else $error("sleep without low power");
  chk_abort_tx: assert property (@(posedge clk) disable iff (rst)
    (rs_q[1] && got && cmd_mode && gbyte[OPC_MSB:OPC_LSB] == OPC_ABORT)
    |=> !tx_in_progress)
    else $error("abort left transmitter on");
  chk_mode_rx: assert property (@(posedge clk) disable iff (rst)
    s_q.st == RMHI_IDLE && rs_q[1] && !cmd_mode && !f_out_v
    && !(got && gbyte[OPC_MSB:OPC_LSB] == OPC_RESET) |=> radio_rx_en)
    else $error("data mode without receive");
  cov_tx:    cover property (@(posedge clk) s_q.st == RMHI_TXCRC);
  cov_write: cover property (@(posedge clk) reg_we);
  cov_sleep: cover property (@(posedge clk) s_q.st == RMHI_SLEEP);
  cov_fwd:   cover property (@(posedge clk) up_v);
endmodule

//--- core/rmhi_fifo.sv
`timescale 1ns/1ns
module rmhi_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_q;
  logic [AW:0]  rp_q;
  logic         wr;
  logic         rd;

  assign in_ready  = (wp_q - rp_q) != (AW+1)'(D);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem[rp_q[AW-1:0]];
  assign wr        = in_valid && in_ready;
  assign rd        = out_valid && out_ready;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_q <= '0;
      rp_q <= '0;
    end else begin
      if (wr) wp_q <= wp_q + 1'b1;
      if (rd) rp_q <= rp_q + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (wr) mem[wp_q[AW-1:0]] <= in_data;
  end
endmodule

//--- pkg/rmhi_pkg.sv
package rmhi_pkg;
  // ==========================================================
  // Serial link timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned BAUD_RATE     = 9600;
  localparam int unsigned BIT_CYCLES    = CLK_HZ / BAUD_RATE;
  localparam int unsigned HALF_CYCLES   = BIT_CYCLES / 2;
  localparam int unsigned INIT_CYCLES   = 16;
  // ==========================================================
  // Command byte layout: opcode in high nibble, count in low
  localparam int unsigned OPC_MSB       = 7;
  localparam int unsigned OPC_LSB       = 4;
  localparam int unsigned CNT_MSB       = 3;
  localparam int unsigned CNT_LSB       = 0;
  localparam logic [3:0]  OPC_RESET     = 4'h1;
  localparam logic [3:0]  OPC_CLR_FLAG  = 4'h2;
  localparam logic [3:0]  OPC_SLEEP     = 4'h3;
  localparam logic [3:0]  OPC_WAKE      = 4'h4;
  localparam logic [3:0]  OPC_ABORT     = 4'h5;
  localparam logic [3:0]  OPC_READ      = 4'h6;
  localparam logic [3:0]  OPC_WRITE     = 4'h7;
  localparam logic [7:0]  START_OF_MSG  = 8'h01;
  // ==========================================================
  // Radio packet layout
  localparam int unsigned REG_COUNT     = 16;
  localparam int unsigned REG_ADDR_IDX  = 0;
  localparam int unsigned REG_DEST_IDX  = 1;
  localparam logic [7:0]  REG_RESET_VAL = 8'h00;
  localparam logic [7:0]  ACK_CODE      = 8'h06;
  localparam int unsigned MAX_PAYLOAD   = 4;
  localparam int unsigned HOP_COUNT     = 8;
  localparam int unsigned ACK_WAIT      = 4000;

  typedef enum logic [3:0] {
    RMHI_INIT   = 4'h0,
    RMHI_IDLE   = 4'h1,
    RMHI_CNUM   = 4'h2,
    RMHI_CWDAT  = 4'h3,
    RMHI_CRDAT  = 4'h4,
    RMHI_TXHDR  = 4'h5,
    RMHI_TXPAY  = 4'h6,
    RMHI_TXCRC  = 4'h7,
    RMHI_ACKW   = 4'h8,
    RMHI_SLEEP  = 4'h9
  } rmhi_state_t;

  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rmhi_byte_t;

  typedef struct packed {
    logic tx_active;
    logic tx_path;
    logic rx_enable;
    logic low_power;
  } rmhi_radio_t;
endpackage
